// ### hdl/cmx_regs.sv
// apb register bank for per-channel mixer settings and per-converter over-range and calibration
// Notes on behaviour
// - channel page register holds oscillator frequency word bits 15:8, reset zero.
// - channel page register holds oscillator frequency word bits 7:0, reset zero.
// - oscillator frequency equals word times sample rate over 65536, word 0..65535.
// - compensation bit 2 gives 6 dB gain in modes 4, 6, 7; reset zero.
// - compensation bit 1 gives 6 dB gain in mode 0; reset one.
// - compensation bit 0 gives 6 dB gain in modes 1 and 3; reset one.
// - each converter page has an 8-bit upper over-range threshold, reset all ones.
// - each converter page has an 8-bit lower over-range threshold, reset zero.
// - converter calibration register bit 3 enables calibration; other bits unused.
// - per-channel bit selects fast or delay-matched over-range indication.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module cmx_regs #(
   parameter int NUM_CH = 4,
   parameter int NUM_ADC = 8
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [cmx_pkg::CMX_ADDR_W-1:0] PADDR,
   input wire logic [cmx_pkg::CMX_DATA_W-1:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [cmx_pkg::CMX_DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output cmx_pkg::cmx_chan_s [NUM_CH-1:0] CHAN_CFG,
   output cmx_pkg::cmx_conv_s [NUM_ADC-1:0] CONV_CFG
);

   logic rst_meta;
   logic rst_n;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta <= 1'h0;
         rst_n <= 1'h0;
      end else begin
         rst_meta <= 1'h1;
         rst_n <= rst_meta;
      end
   end

   // address decode
   logic kind;
   logic [cmx_pkg::CMX_PAGE_W-1:0] page;
   logic [cmx_pkg::CMX_IDX_W-1:0] idx;
   logic page_ok;
   logic idx_ok;
   logic hit;

   always_comb begin
      kind = PADDR[cmx_pkg::CMX_KIND_BIT];
      page = PADDR[cmx_pkg::CMX_PAGE_LSB +: cmx_pkg::CMX_PAGE_W];
      idx = PADDR[cmx_pkg::CMX_IDX_LSB +: cmx_pkg::CMX_IDX_W];
      if (kind == cmx_pkg::CMX_KIND_CHANNEL) begin
         page_ok = (32'(page) < NUM_CH);
         idx_ok = (idx == cmx_pkg::CMX_IDX_QSEL) || (idx == cmx_pkg::CMX_IDX_FREQ_HI) ||
                  (idx == cmx_pkg::CMX_IDX_FREQ_LO) || (idx == cmx_pkg::CMX_IDX_COMP);
      end else begin
         page_ok = (32'(page) < NUM_ADC);
         idx_ok = (idx == cmx_pkg::CMX_IDX_UPPER) || (idx == cmx_pkg::CMX_IDX_LOWER) ||
                  (idx == cmx_pkg::CMX_IDX_CAL) || (idx == cmx_pkg::CMX_IDX_CAL_STAT);
      end
      // unused upper address bits and byte offsets must be zero for a hit
      hit = page_ok && idx_ok && (PADDR[1:0] == 2'h0) &&
            (PADDR[cmx_pkg::CMX_ADDR_W-1] == 1'h0) &&
            (PADDR[cmx_pkg::CMX_KIND_BIT-1:cmx_pkg::CMX_PAGE_LSB+cmx_pkg::CMX_PAGE_W] == '0);
   end

   // apb handshake: answer in the first access cycle, registered
   cmx_pkg::cmx_phase_e phase;
   cmx_pkg::cmx_phase_e next_phase;
   logic [cmx_pkg::CMX_DATA_W-1:0] next_prdata;
   logic next_pslverr;
   logic wr_ok;
   logic [7:0] rd_byte;

   always_comb begin
      next_phase = cmx_pkg::CMX_PH_IDLE;
      next_prdata = '0;
      next_pslverr = 1'h0;
      rd_byte = 8'h00;
      if (kind == cmx_pkg::CMX_KIND_CHANNEL && page_ok) begin
         case (idx)
            cmx_pkg::CMX_IDX_QSEL: begin
               rd_byte[cmx_pkg::CMX_QSEL_BIT] = CHAN_CFG[page].quick_overrange_select;
            end
            cmx_pkg::CMX_IDX_FREQ_HI: begin
               rd_byte = CHAN_CFG[page].osc_freq_word[15:8];
            end
            cmx_pkg::CMX_IDX_FREQ_LO: begin
               rd_byte = CHAN_CFG[page].osc_freq_word[7:0];
            end
            cmx_pkg::CMX_IDX_COMP: begin
               // upper five bits stay zero on readback
               rd_byte[cmx_pkg::CMX_COMP467_BIT] = CHAN_CFG[page].comp_boost_modes_four_six_seven;
               rd_byte[cmx_pkg::CMX_COMP0_BIT] = CHAN_CFG[page].comp_boost_mode_zero;
               rd_byte[cmx_pkg::CMX_COMP13_BIT] = CHAN_CFG[page].comp_boost_modes_one_three;
            end
            default: begin
               rd_byte = 8'h00;
            end
         endcase
      end else if (kind == cmx_pkg::CMX_KIND_CONVERTER && page_ok) begin
         case (idx)
            cmx_pkg::CMX_IDX_UPPER: begin
               rd_byte = CONV_CFG[page].fast_overrange_upper_threshold;
            end
            cmx_pkg::CMX_IDX_LOWER: begin
               rd_byte = CONV_CFG[page].fast_overrange_lower_threshold;
            end
            cmx_pkg::CMX_IDX_CAL: begin
               rd_byte[cmx_pkg::CMX_CAL_EN_BIT] = CONV_CFG[page].cal_enable;
            end
            cmx_pkg::CMX_IDX_CAL_STAT: begin
               rd_byte[cmx_pkg::CMX_CAL_DONE_BIT] = CONV_CFG[page].cal_toggled;
            end
            default: begin
               rd_byte = 8'h00;
            end
         endcase
      end
      case (phase)
         cmx_pkg::CMX_PH_IDLE: begin
            if (PSEL && !PENABLE) begin
               next_phase = cmx_pkg::CMX_PH_ACK;
               next_pslverr = !hit;
               if (!PWRITE && hit) begin
                  next_prdata = {{(cmx_pkg::CMX_DATA_W-cmx_pkg::CMX_BYTE_W){1'h0}}, rd_byte};
               end
            end
         end
         cmx_pkg::CMX_PH_ACK: begin
            next_phase = cmx_pkg::CMX_PH_IDLE;
         end
         default: begin
            next_phase = cmx_pkg::CMX_PH_IDLE;
         end
      endcase
      // a write lands only at the edge where the master sees pready
      wr_ok = PSEL && PENABLE && PREADY && PWRITE && hit && PSTRB[0];
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         phase <= cmx_pkg::CMX_PH_IDLE;
         PREADY <= 1'h0;
         PRDATA <= '0;
         PSLVERR <= 1'h0;
      end else begin
         phase <= next_phase;
         PREADY <= (next_phase == cmx_pkg::CMX_PH_ACK);
         PRDATA <= next_prdata;
         PSLVERR <= next_pslverr;
      end
   end

   // register state: each page written only when its own page number is decoded
   cmx_pkg::cmx_chan_s [NUM_CH-1:0] next_chan;
   cmx_pkg::cmx_conv_s [NUM_ADC-1:0] next_conv;
   logic [7:0] wbyte;

   always_comb begin
      next_chan = CHAN_CFG;
      next_conv = CONV_CFG;
      wbyte = PWDATA[cmx_pkg::CMX_BYTE_W-1:0];
      for (int c = 0; c < NUM_CH; c++) begin
         if (wr_ok && kind == cmx_pkg::CMX_KIND_CHANNEL && 32'(page) == c) begin
            case (idx)
               cmx_pkg::CMX_IDX_QSEL: begin
                  next_chan[c].quick_overrange_select = wbyte[cmx_pkg::CMX_QSEL_BIT];
               end
               cmx_pkg::CMX_IDX_FREQ_HI: begin
                  next_chan[c].osc_freq_word[15:8] = wbyte;
               end
               cmx_pkg::CMX_IDX_FREQ_LO: begin
                  next_chan[c].osc_freq_word[7:0] = wbyte;
               end
               cmx_pkg::CMX_IDX_COMP: begin
                  next_chan[c].comp_boost_modes_four_six_seven =
                     wbyte[cmx_pkg::CMX_COMP467_BIT];
                  next_chan[c].comp_boost_mode_zero = wbyte[cmx_pkg::CMX_COMP0_BIT];
                  next_chan[c].comp_boost_modes_one_three = wbyte[cmx_pkg::CMX_COMP13_BIT];
               end
               default: begin
                  next_chan[c] = CHAN_CFG[c];
               end
            endcase
         end
      end
      for (int a = 0; a < NUM_ADC; a++) begin
         if (wr_ok && kind == cmx_pkg::CMX_KIND_CONVERTER && 32'(page) == a) begin
            case (idx)
               cmx_pkg::CMX_IDX_UPPER: begin
                  next_conv[a].fast_overrange_upper_threshold = wbyte;
               end
               cmx_pkg::CMX_IDX_LOWER: begin
                  next_conv[a].fast_overrange_lower_threshold = wbyte;
               end
               cmx_pkg::CMX_IDX_CAL: begin
                  next_conv[a].cal_enable = wbyte[cmx_pkg::CMX_CAL_EN_BIT];
                  // falling enable marks the start-up toggle as done; any write with enable set re-arms it
                  if (CONV_CFG[a].cal_enable && !wbyte[cmx_pkg::CMX_CAL_EN_BIT]) begin
                     next_conv[a].cal_toggled = 1'h1;
                  end else if (wbyte[cmx_pkg::CMX_CAL_EN_BIT]) begin
                     next_conv[a].cal_toggled = 1'h0;
                  end
               end
               default: begin
                  next_conv[a] = CONV_CFG[a];
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < NUM_CH; c++) begin
            CHAN_CFG[c].quick_overrange_select <= cmx_pkg::CMX_QSEL_RST;
            CHAN_CFG[c].comp_boost_modes_four_six_seven <= cmx_pkg::CMX_COMP467_RST;
            CHAN_CFG[c].comp_boost_mode_zero <= cmx_pkg::CMX_COMP0_RST;
            CHAN_CFG[c].comp_boost_modes_one_three <= cmx_pkg::CMX_COMP13_RST;
            CHAN_CFG[c].osc_freq_word <= cmx_pkg::CMX_FREQ_RST;
         end
         for (int a = 0; a < NUM_ADC; a++) begin
            CONV_CFG[a].fast_overrange_upper_threshold <= cmx_pkg::CMX_UPPER_RST;
            CONV_CFG[a].fast_overrange_lower_threshold <= cmx_pkg::CMX_LOWER_RST;
            CONV_CFG[a].cal_enable <= cmx_pkg::CMX_CAL_RST;
            CONV_CFG[a].cal_toggled <= 1'h0;
         end
      end else begin
         CHAN_CFG <= next_chan;
         CONV_CFG <= next_conv;
      end
   end

   // the oscillator itself scales osc_freq_word by fs / 2^16; only the word lives here

   property p_reset_values;
      @(posedge CLK) disable iff (!RST_N)
      !rst_n |-> CONV_CFG[0].fast_overrange_upper_threshold == 8'hFF &&
                 CONV_CFG[0].fast_overrange_lower_threshold == 8'h00 &&
                 CHAN_CFG[0].osc_freq_word == 16'h0000 && !CONV_CFG[0].cal_enable;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset value");

   property p_comp_reset;
      @(posedge CLK) disable iff (!RST_N)
      !rst_n |-> CHAN_CFG[0].comp_boost_mode_zero && CHAN_CFG[0].comp_boost_modes_one_three &&
                 !CHAN_CFG[0].comp_boost_modes_four_six_seven;
   endproperty
   a_comp_reset: assert property (p_comp_reset) else $error("bad compensation reset");

   property p_freq_hi;
      @(posedge CLK) disable iff (!rst_n)
      (wr_ok && kind == cmx_pkg::CMX_KIND_CHANNEL && idx == cmx_pkg::CMX_IDX_FREQ_HI) |=>
         CHAN_CFG[$past(page)].osc_freq_word[15:8] == $past(PWDATA[7:0]) &&
         CHAN_CFG[$past(page)].osc_freq_word[7:0] == $past(CHAN_CFG[page].osc_freq_word[7:0]);
   endproperty
   a_freq_hi: assert property (p_freq_hi) else $error("upper frequency byte wrong");

   property p_freq_lo;
      @(posedge CLK) disable iff (!rst_n)
      (wr_ok && kind == cmx_pkg::CMX_KIND_CHANNEL && idx == cmx_pkg::CMX_IDX_FREQ_LO) |=>
         CHAN_CFG[$past(page)].osc_freq_word[7:0] == $past(PWDATA[7:0]) &&
         CHAN_CFG[$past(page)].osc_freq_word[15:8] == $past(CHAN_CFG[page].osc_freq_word[15:8]);
   endproperty
   a_freq_lo: assert property (p_freq_lo) else $error("lower frequency byte wrong");

   property p_comp_write;
      @(posedge CLK) disable iff (!rst_n)
      (wr_ok && kind == cmx_pkg::CMX_KIND_CHANNEL && idx == cmx_pkg::CMX_IDX_COMP) |=>
         {CHAN_CFG[$past(page)].comp_boost_modes_four_six_seven,
          CHAN_CFG[$past(page)].comp_boost_mode_zero,
          CHAN_CFG[$past(page)].comp_boost_modes_one_three} == $past(PWDATA[2:0]);
   endproperty
   a_comp_write: assert property (p_comp_write) else $error("compensation bits wrong");

   property p_unused_zero;
      @(posedge CLK) disable iff (!rst_n)
      (PSEL && PENABLE && PREADY && !PWRITE) |-> PRDATA[31:8] == 24'h000000;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

   property p_cal_write;
      @(posedge CLK) disable iff (!rst_n)
      (wr_ok && kind == cmx_pkg::CMX_KIND_CONVERTER && idx == cmx_pkg::CMX_IDX_CAL) |=>
         CONV_CFG[$past(page)].cal_enable == $past(PWDATA[3]);
   endproperty
   a_cal_write: assert property (p_cal_write) else $error("calibration enable wrong");

   property p_thresholds;
      @(posedge CLK) disable iff (!rst_n)
      (wr_ok && kind == cmx_pkg::CMX_KIND_CONVERTER && idx == cmx_pkg::CMX_IDX_LOWER) |=>
         CONV_CFG[$past(page)].fast_overrange_lower_threshold == $past(PWDATA[7:0]) &&
         CONV_CFG[$past(page)].fast_overrange_upper_threshold ==
            $past(CONV_CFG[page].fast_overrange_upper_threshold);
   endproperty
   a_thresholds: assert property (p_thresholds) else $error("lower threshold wrong");

   property p_qsel;
      @(posedge CLK) disable iff (!rst_n)
      (wr_ok && kind == cmx_pkg::CMX_KIND_CHANNEL && idx == cmx_pkg::CMX_IDX_QSEL) |=>
         CHAN_CFG[$past(page)].quick_overrange_select == $past(PWDATA[6]);
   endproperty
   a_qsel: assert property (p_qsel) else $error("over-range select wrong");

   property p_isolation;
      @(posedge CLK) disable iff (!rst_n)
      (wr_ok && !(kind == cmx_pkg::CMX_KIND_CHANNEL && page == 3'h0)) |=> $stable(CHAN_CFG[0]);
   endproperty
   a_isolation: assert property (p_isolation) else $error("channel 0 changed by other page");

   property p_one_cycle_ready;
      @(posedge CLK) disable iff (!rst_n)
      (PSEL && !PENABLE) |=> PREADY ##1 !PREADY;
   endproperty
   a_one_cycle_ready: assert property (p_one_cycle_ready) else $error("pready not one cycle");

endmodule : cmx_regs

// ### hdl/cmx_pkg.sv
// constants, register map and field layouts of the mixer and converter control bank
package cmx_pkg;

   // apb address layout: byte address = 4 * register index
   localparam int CMX_IDX_LSB = 2;
   localparam int CMX_IDX_W = 8;
   localparam int CMX_PAGE_LSB = 10;
   localparam int CMX_PAGE_W = 3;
   localparam int CMX_KIND_BIT = 14;
   localparam int CMX_ADDR_W = 16;
   localparam int CMX_DATA_W = 32;
   localparam logic CMX_KIND_CHANNEL = 1'h0;
   localparam logic CMX_KIND_CONVERTER = 1'h1;

   // channel page register indices
   localparam logic [7:0] CMX_IDX_QSEL = 8'h27;
   localparam logic [7:0] CMX_IDX_FREQ_HI = 8'h7A;
   localparam logic [7:0] CMX_IDX_FREQ_LO = 8'h7B;
   localparam logic [7:0] CMX_IDX_COMP = 8'h7E;
   // converter page register indices
   localparam logic [7:0] CMX_IDX_UPPER = 8'h07;
   localparam logic [7:0] CMX_IDX_LOWER = 8'h08;
   localparam logic [7:0] CMX_IDX_CAL = 8'hD5;
   localparam logic [7:0] CMX_IDX_CAL_STAT = 8'hD6;

   // field positions
   localparam int CMX_QSEL_BIT = 6;
   localparam int CMX_COMP467_BIT = 2;
   localparam int CMX_COMP0_BIT = 1;
   localparam int CMX_COMP13_BIT = 0;
   localparam int CMX_CAL_EN_BIT = 3;
   localparam int CMX_CAL_DONE_BIT = 0;
   localparam int CMX_BYTE_W = 8;

   // reset values
   localparam logic [15:0] CMX_FREQ_RST = 16'h0000;
   localparam logic CMX_COMP467_RST = 1'h0;
   localparam logic CMX_COMP0_RST = 1'h1;
   localparam logic CMX_COMP13_RST = 1'h1;
   localparam logic CMX_QSEL_RST = 1'h0;
   localparam logic [7:0] CMX_UPPER_RST = 8'hFF;
   localparam logic [7:0] CMX_LOWER_RST = 8'h00;
   localparam logic CMX_CAL_RST = 1'h0;

   typedef struct packed {
      logic quick_overrange_select;
      logic comp_boost_modes_four_six_seven;
      logic comp_boost_mode_zero;
      logic comp_boost_modes_one_three;
      logic [15:0] osc_freq_word;
   } cmx_chan_s;

   typedef struct packed {
      logic [7:0] fast_overrange_upper_threshold;
      logic [7:0] fast_overrange_lower_threshold;
      logic cal_enable;
      logic cal_toggled;
   } cmx_conv_s;

   typedef enum logic [0:0] {
      CMX_PH_IDLE,
      CMX_PH_ACK
   } cmx_phase_e;

endpackage : cmx_pkg

// ### testbench/cmx_testbench.sv
// self-checking bench for the mixer and converter control register bank
`timescale 1ns/1ns
module testbench;
   localparam int NCH = 4;
   localparam int NADC = 8;
   localparam int TIME_LIMIT = 20000;
   typedef struct {
      logic kind;
      int page;
      logic [7:0] idx;
      logic [7:0] wdata;
      logic [3:0] strb;
      logic [7:0] exp;
   } cmx_row_s;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   cmx_pkg::cmx_chan_s [NCH-1:0] chan_cfg;
   cmx_pkg::cmx_conv_s [NADC-1:0] conv_cfg;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic chained = 1'h0;
   logic [31:0] rd;
   logic err;
   cmx_row_s rows [10];
   logic [31:0] exp_ch [NCH];
   logic [31:0] exp_cv [NADC];

   cmx_regs #(.NUM_CH(NCH), .NUM_ADC(NADC)) dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CHAN_CFG(chan_cfg),
      .CONV_CFG(conv_cfg));

   initial begin
      forever #25 clk = ~clk;
   end

   function automatic logic [15:0] addr_of(input logic kind, input int page,
      input logic [7:0] idx);
      addr_of = {1'h0, kind, 1'h0, page[2:0], idx, 2'h0};
   endfunction : addr_of

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   // keep leaves psel up so the next setup follows the access edge directly
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic keep);
      if (!chained) @(posedge clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'h1;
      // no wait-state count assumed; only the bench timeout ends a hung access
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      if (!keep) begin
         psel <= 1'h0;
         penable <= 1'h0;
      end
      chained = keep;
   endtask : apb

   task automatic rd_reg(input logic kind, input int page, input logic [7:0] idx);
      apb(1'h0, addr_of(kind, page, idx), 32'h00000000, 4'hF, 1'h0);
   endtask : rd_reg

   task automatic wr_reg(input logic kind, input int page, input logic [7:0] idx,
      input logic [7:0] d);
      apb(1'h1, addr_of(kind, page, idx), {24'h000000, d}, 4'hF, 1'h0);
   endtask : wr_reg

   task automatic check_reset_state();
      for (int p = 0; p < NCH; p++) begin
         rd_reg(cmx_pkg::CMX_KIND_CHANNEL, p, cmx_pkg::CMX_IDX_FREQ_HI);
         check(rd, 32'h00000000);
         rd_reg(cmx_pkg::CMX_KIND_CHANNEL, p, cmx_pkg::CMX_IDX_FREQ_LO);
         check(rd, 32'h00000000);
         rd_reg(cmx_pkg::CMX_KIND_CHANNEL, p, cmx_pkg::CMX_IDX_COMP);
         check(rd, 32'h00000003);
         rd_reg(cmx_pkg::CMX_KIND_CHANNEL, p, cmx_pkg::CMX_IDX_QSEL);
         check(rd, 32'h00000000);
         check(32'(chan_cfg[p]), 32'h00030000);
      end
      for (int q = 0; q < NADC; q++) begin
         rd_reg(cmx_pkg::CMX_KIND_CONVERTER, q, cmx_pkg::CMX_IDX_UPPER);
         check(rd, 32'h000000FF);
         rd_reg(cmx_pkg::CMX_KIND_CONVERTER, q, cmx_pkg::CMX_IDX_LOWER);
         check(rd, 32'h00000000);
         rd_reg(cmx_pkg::CMX_KIND_CONVERTER, q, cmx_pkg::CMX_IDX_CAL);
         check(rd, 32'h00000000);
         check(32'(conv_cfg[q]), 32'h0003FC00);
      end
   endtask : check_reset_state

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge clk) begin
      cycles++;
      if (cycles == TIME_LIMIT) begin
         bad_count++;
         report_and_stop();
      end
   end

   initial begin
      rows[0] = '{1'h0, 1, 8'h7A, 8'hA5, 4'hF, 8'hA5};
      rows[1] = '{1'h0, 1, 8'h7B, 8'h3C, 4'hF, 8'h3C};
      rows[2] = '{1'h0, 2, 8'h7E, 8'hFF, 4'hF, 8'h07};
      rows[3] = '{1'h0, 3, 8'h7E, 8'h04, 4'hF, 8'h04};
      rows[4] = '{1'h0, 0, 8'h27, 8'hFF, 4'hF, 8'h40};
      rows[5] = '{1'h1, 3, 8'h07, 8'h5A, 4'hF, 8'h5A};
      rows[6] = '{1'h1, 7, 8'h08, 8'hC3, 4'hF, 8'hC3};
      rows[7] = '{1'h1, 5, 8'hD5, 8'hFF, 4'hF, 8'h08};
      rows[8] = '{1'h1, 6, 8'h07, 8'h11, 4'h0, 8'hFF};
      rows[9] = '{1'h1, 6, 8'hD6, 8'hFF, 4'hF, 8'h00};
      exp_ch = '{32'h000B0000, 32'h0003A53C, 32'h00070000, 32'h00040000};
      foreach (exp_cv[i]) exp_cv[i] = 32'h0003FC00;
      exp_cv[3] = 32'h00016800;
      exp_cv[5] = 32'h0003FC02;
      exp_cv[7] = 32'h0003FF0C;
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      check_reset_state();
      $display("reset value test done");
      foreach (rows[i]) begin
         apb(1'h1, addr_of(rows[i].kind, rows[i].page, rows[i].idx),
            {24'h000000, rows[i].wdata}, rows[i].strb, 1'h0);
         rd_reg(rows[i].kind, rows[i].page, rows[i].idx);
         check(rd, {24'h000000, rows[i].exp});
      end
      // every page compared, so a write leaking into a neighbour shows here
      foreach (exp_ch[i]) check(32'(chan_cfg[i]), exp_ch[i]);
      foreach (exp_cv[i]) check(32'(conv_cfg[i]), exp_cv[i]);
      $display("register table test done");
      apb(1'h1, addr_of(1'h0, 2, 8'h7B), 32'h00000077, 4'hF, 1'h1);
      apb(1'h0, addr_of(1'h0, 2, 8'h7B), 32'h00000000, 4'hF, 1'h0);
      check(rd, 32'h00000077);
      check(32'(chan_cfg[2].osc_freq_word), 32'h00000077);
      $display("back-to-back test done");
      wr_reg(1'h1, 0, cmx_pkg::CMX_IDX_CAL, 8'h08);
      // the write lands at the access edge itself; look one edge later
      @(posedge clk);
      check(32'(conv_cfg[0].cal_enable), 32'h00000001);
      wr_reg(1'h1, 0, cmx_pkg::CMX_IDX_CAL, 8'h00);
      rd_reg(1'h1, 0, cmx_pkg::CMX_IDX_CAL_STAT);
      check(rd, 32'h00000001);
      check(32'(conv_cfg[0]), 32'h0003FC01);
      wr_reg(1'h1, 0, cmx_pkg::CMX_IDX_CAL, 8'h08);
      rd_reg(1'h1, 0, cmx_pkg::CMX_IDX_CAL_STAT);
      check(rd, 32'h00000000);
      $display("calibration toggle test done");
      rd_reg(1'h0, 4, 8'h7A);
      check({err, rd[30:0]}, 32'h80000000);
      apb(1'h1, 16'h01E9, 32'h000000FF, 4'hF, 1'h0);
      check({31'h0, err}, 32'h00000001);
      wr_reg(1'h1, 1, 8'h09, 8'h55);
      check({31'h0, err}, 32'h00000001);
      check(32'(chan_cfg[1]), 32'h0003A53C);
      $display("unmapped access test done");
      @(posedge clk);
      rst_n <= 1'h0;
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      check_reset_state();
      $display("mid-run reset test done");
      report_and_stop();
   end
endmodule : testbench
